/* File: logic/cil_config_init.sv */
/*
 * configuration completion, initialisation, error recovery and chain
 * control, with an AXI4-Lite register slave.
 * assumes a bit loader on clk_sys reports done and frame errors, and
 * that board wiring resolves open-drain lines from the enables.
 */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - after all bits, release completion line; init waits for it high.
// - after configuration, serial memory pins become tri-stated inputs.
// - init clocked by internal 10 MHz oscillator or user clock.
// - internal oscillator supplies every init cycle with no external clock.
// - count 3185 init clocks after completion line high, then user mode.
// - configuration transfer is unaffected by the user start-up clock.
// - with user clock selected, init advances only on its edges.
// - init-complete pin low once enabled, released when init completes.
// - init-complete pin undriven during reset and early configuration.
// - user mode drops weak pull-ups and enables user I/O.
// - frame error drives status line low, completion stays low.
// - auto-restart pulses flash select, releases status within 230 us.
// - reconfig low resets device, pulls status and completion low.
// - reconfiguration begins after request high and status released.
// - chain-enable out driven low once own data is captured.
// - first device is active master, later devices passive slaves.
// - completion line released at hand-off; all start init together.
// - failing chain device drives status low; chain restarts.
// - stay in reset while request or status line is low.
module cil_config_init
   import cil_pkg::*;
#(
   parameter int RESET_TMO = RESET_TMO_CYC
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // bit loader, same clock
   input  wire logic              cfg_bits_done,
   input  wire logic              cfg_frame_error,
   // reconfiguration request and user clock pins
   input  wire logic              reconfig_request_n,
   input  wire logic              user_startup_clock,
   // open-drain error status line
   input  wire logic              error_status_line_n_i,
   output logic                   error_status_line_n_o,
   output logic                   error_status_line_n_oe,
   // open-drain load complete line
   input  wire logic              load_complete_line_i,
   output logic                   load_complete_line_o,
   output logic                   load_complete_line_oe,
   // chain enable
   input  wire logic              chain_enable_in_n,
   output logic                   chain_enable_out_n_o,
   output logic                   chain_enable_out_n_oe,
   // init complete pin
   output logic                   init_done_o,
   output logic                   init_done_oe,
   // serial memory pins
   output logic                   flash_select_n_o,
   output logic                   flash_select_n_oe,
   output logic                   serial_pins_oe,
   // user i/o control
   output logic                   user_pullup_en,
   output logic                   user_io_en
);
   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   logic [SYNC_N-1:0] pin_raw;
   logic [SYNC_N-1:0] sync1_reg;
   logic [SYNC_N-1:0] sync2_reg;
   logic              uclk_d_reg;
   logic              chain_s1_reg;
   logic              chain_s2_reg;
   assign pin_raw[SY_RECFG] = reconfig_request_n;
   assign pin_raw[SY_STAT]  = error_status_line_n_i;
   assign pin_raw[SY_DONE]  = load_complete_line_i;
   assign pin_raw[SY_UCLK]  = user_startup_clock;
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
         always_ff @(posedge clk_sys) begin
            sync1_reg[gi] <= rst ? 1'b1 : pin_raw[gi];
            sync2_reg[gi] <= rst ? 1'b1 : sync1_reg[gi];
         end
      end
   endgenerate
   always_ff @(posedge clk_sys) begin
      uclk_d_reg   <= rst ? 1'b1 : sync2_reg[SY_UCLK];
      chain_s1_reg <= rst ? 1'b1 : chain_enable_in_n;
      chain_s2_reg <= rst ? 1'b1 : chain_s1_reg;
   end
   wire recfg_s = sync2_reg[SY_RECFG];
   wire stat_s  = sync2_reg[SY_STAT];
   wire done_s  = sync2_reg[SY_DONE];
   wire chain_s = ~chain_s2_reg;
   // ***************************************************************
   // initialisation clock
   // ***************************************************************
   cil_ctrl_t        ctrl_reg;
   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] div_next;
   wire osc_tick  = (div_reg == DIV_W'(OSC_DIV - 1));
   wire uclk_rise = sync2_reg[SY_UCLK] & ~uclk_d_reg;
   // free-running divider needs no external clock
   assign div_next = osc_tick ? '0 : div_reg + 1'b1;
   // user clock only matters here, never during loading
   wire init_tick = ctrl_reg.user_clk_sel ? uclk_rise : osc_tick;
   always_ff @(posedge clk_sys) begin
      div_reg <= rst ? '0 : div_next;
   end
   // ***************************************************************
   // stage sequencer
   // ***************************************************************
   cil_state_t       state_reg;
   cil_state_t       state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [TMO_W-1:0] tmo_reg;
   logic [TMO_W-1:0] tmo_next;
   wire init_last = (cnt_reg == CNT_W'(INIT_CYCLES - 1));
   wire tmo_last  = (tmo_reg == TMO_W'(RESET_TMO - 1));
   // loader done only counts while this device holds the chain token
   wire bits_done = cfg_bits_done & chain_s;
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RESET:
            // both lines must be high to leave
            if (recfg_s && stat_s) begin
               state_next = ST_CONFIG;
            end
         ST_CONFIG:
            if (!stat_s) begin
               state_next = ST_RESET;
            end else if (cfg_frame_error) begin
               state_next = ST_ERROR;
            end else if (bits_done) begin
               state_next = ST_WAIT;
            end
         ST_WAIT:
            if (!stat_s) begin
               state_next = ST_RESET;
            end else if (done_s) begin
               state_next = ST_INIT;
            end
         ST_INIT:
            if (!stat_s) begin
               state_next = ST_RESET;
            end else if (init_tick && init_last) begin
               state_next = ST_USER;
            end
         ST_USER:
            state_next = ST_USER;
         ST_ERROR:
            if (ctrl_reg.auto_restart && tmo_last) begin
               state_next = ST_RESET;
            end
         default:
            state_next = ST_RESET;
      endcase
      // request low wins from any stage
      if (!recfg_s) begin
         state_next = ST_RESET;
      end
   end
   // counter held at zero outside init, cleared on any exit
   assign cnt_next = (state_reg != ST_INIT || state_next != ST_INIT) ? '0 :
                     init_tick ? cnt_reg + 1'b1 : cnt_reg;
   assign tmo_next = (state_reg != ST_ERROR) ? '0 :
                     tmo_last ? tmo_reg : tmo_reg + 1'b1;
   always_ff @(posedge clk_sys) begin
      state_reg <= rst ? ST_RESET : state_next;
      cnt_reg   <= rst ? '0 : cnt_next;
      tmo_reg   <= rst ? '0 : tmo_next;
   end
   // ***************************************************************
   // pin drive, registered from the next stage
   // ***************************************************************
   wire in_rst  = (state_next == ST_RESET);
   wire in_cfg  = (state_next == ST_CONFIG);
   wire in_err  = (state_next == ST_ERROR);
   wire in_user = (state_next == ST_USER);
   wire handed  = (state_next == ST_WAIT) || (state_next == ST_INIT) || in_user;
   wire [TMO_W-1:0] tmo_n = (state_reg == ST_ERROR) ? tmo_next : '0;
   // status low on error and while the request is held
   wire stat_oe_n = in_err || (in_rst && !recfg_s);
   // completion held low until own data is in
   wire done_oe_n = !handed;
   // option bit drives low only while waiting for completion high and while initialising
   wire idone_n   = ctrl_reg.init_done_en &&
                    ((state_next == ST_WAIT) || (state_next == ST_INIT));
   // high pulse on flash select resets the memory
   wire fpulse_n  = in_err && (tmo_n < TMO_W'(FLASH_PULSE_CYC));
   logic zero_reg;
   always_ff @(posedge clk_sys) begin
      zero_reg               <= 1'b0;
      error_status_line_n_oe <= rst ? 1'b1 : stat_oe_n;
      load_complete_line_oe  <= rst ? 1'b1 : done_oe_n;
      chain_enable_out_n_oe  <= rst ? 1'b0 : handed;
      init_done_oe           <= rst ? 1'b0 : idone_n;
      flash_select_n_oe      <= rst ? 1'b0 : (in_cfg || fpulse_n);
      flash_select_n_o       <= rst ? 1'b1 : fpulse_n;
      serial_pins_oe         <= rst ? 1'b0 : in_cfg;
      user_pullup_en         <= rst ? 1'b1 : !in_user;
      user_io_en             <= rst ? 1'b0 : in_user;
   end
   assign error_status_line_n_o = zero_reg;
   assign load_complete_line_o  = zero_reg;
   assign chain_enable_out_n_o  = zero_reg;
   assign init_done_o           = zero_reg;
   // ***************************************************************
   // register slave
   // ***************************************************************
   function automatic cil_sel_t reg_sel(input logic [ADDR_W-1:0] a);
      unique case (a)
         OFF_CTRL:  reg_sel = SEL_CTRL;
         OFF_STAT:  reg_sel = SEL_STAT;
         OFF_COUNT: reg_sel = SEL_COUNT;
         default:   reg_sel = SEL_NONE;
      endcase
   endfunction
   logic              aw_held_reg;
   logic              w_held_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs  = s_axi_wvalid & s_axi_wready;
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire aw_ok = aw_held_reg | aw_hs;
   wire w_ok  = w_held_reg | w_hs;
   wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
   wire [ADDR_W-1:0] wa = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
   wire [31:0]       wd = w_held_reg ? w_data_reg : s_axi_wdata;
   wire [3:0]        ws = w_held_reg ? w_strb_reg : s_axi_wstrb;
   wire cil_sel_t    wsel = reg_sel(wa);
   wire cil_sel_t    rsel = reg_sel(s_axi_araddr);
   wire aw_held_n = aw_ok & ~do_wr;
   wire w_held_n  = w_ok & ~do_wr;
   wire bvalid_n  = do_wr | (s_axi_bvalid & ~s_axi_bready);
   wire rvalid_n  = ar_hs | (s_axi_rvalid & ~s_axi_rready);
   wire ctrl_wr   = do_wr & (wsel == SEL_CTRL) & ws[0];
   wire [31:0] stat_word = {26'h0, recfg_s, stat_s, done_s, state_reg};
   wire [31:0] rd_word =
      (rsel == SEL_CTRL)  ? {29'h0, ctrl_reg} :
      (rsel == SEL_STAT)  ? stat_word :
      (rsel == SEL_COUNT) ? {20'h0, cnt_reg} : 32'h0;
   always_ff @(posedge clk_sys) begin
      aw_held_reg   <= rst ? 1'b0 : aw_held_n;
      w_held_reg    <= rst ? 1'b0 : w_held_n;
      s_axi_awready <= rst ? 1'b0 : ~aw_held_n & ~bvalid_n;
      s_axi_wready  <= rst ? 1'b0 : ~w_held_n & ~bvalid_n;
      s_axi_bvalid  <= rst ? 1'b0 : bvalid_n;
      s_axi_arready <= rst ? 1'b0 : ~rvalid_n;
      s_axi_rvalid  <= rst ? 1'b0 : rvalid_n;
      ctrl_reg      <= rst ? cil_ctrl_t'(CTRL_RST) :
                       ctrl_wr ? cil_ctrl_t'(wd[2:0]) : ctrl_reg;
   end
   always_ff @(posedge clk_sys) begin
      if (aw_hs) begin
         aw_addr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
   end
   // only the control word is writable; other writes and unmapped reads answer slverr
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_bresp <= RESP_OKAY;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
      end else begin
         if (do_wr) begin
            s_axi_bresp <= (wsel == SEL_CTRL) ? RESP_OKAY : RESP_SLV;
         end
         if (ar_hs) begin
            s_axi_rresp <= (rsel == SEL_NONE) ? RESP_SLV : RESP_OKAY;
            s_axi_rdata <= rd_word;
         end
      end
   end
   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wait_hold_a: assert property ((state_reg == ST_WAIT && !done_s && stat_s && recfg_s)
      |=> state_reg == ST_WAIT) else $error("init began before completion high");
   serial_off_a: assert property (state_reg != ST_CONFIG |-> !serial_pins_oe)
      else $error("serial pins driven outside configuration");
   tick_gate_a: assert property ((state_reg == ST_INIT && !init_tick && stat_s && recfg_s)
      |=> $stable(cnt_reg)) else $error("init advanced without a clock tick");
   osc_space_a: assert property ((osc_tick && !ctrl_reg.user_clk_sel) |=> !osc_tick[*8])
      else $error("internal tick spacing wrong");
   init_len_a: assert property ($rose(state_reg == ST_USER) |-> $past(init_last))
      else $error("user mode entered at wrong count");
   idone_low_a: assert property ((state_reg == ST_INIT && ctrl_reg.init_done_en)
      |-> init_done_oe) else $error("init complete pin not driven low");
   idone_free_a: assert property (state_reg inside {ST_RESET, ST_CONFIG}
      |-> !init_done_oe) else $error("init complete pin driven too early");
   user_io_a: assert property (state_reg == ST_USER |-> user_io_en && !user_pullup_en)
      else $error("user i/o not released in user mode");
   err_lines_a: assert property (state_reg == ST_ERROR
      |-> error_status_line_n_oe && load_complete_line_oe)
      else $error("error lines not held low");
   err_tmo_a: assert property (state_reg == ST_ERROR |-> tmo_reg < TMO_W'(RESET_TMO))
      else $error("reset timeout overrun");
   req_reset_a: assert property (!recfg_s |=> state_reg == ST_RESET
      && error_status_line_n_oe && load_complete_line_oe)
      else $error("request low did not reset");
   rst_stay_a: assert property ((state_reg == ST_RESET && !(recfg_s && stat_s))
      |=> state_reg == ST_RESET) else $error("left reset too early");
   chain_out_a: assert property (state_reg == ST_WAIT |-> chain_enable_out_n_oe
      && !load_complete_line_oe) else $error("hand-off lines wrong");
   chain_rel_a: assert property (state_reg == ST_RESET |-> !chain_enable_out_n_oe
      && cnt_reg == '0) else $error("reset stage left chain or count set");
   cv_user: cover property ($rose(state_reg == ST_USER));
   cv_error: cover property ($rose(state_reg == ST_ERROR));
   cv_retry: cover property (state_reg == ST_ERROR ##1 state_reg == ST_RESET);
   cv_reconf: cover property (state_reg == ST_USER ##1 state_reg == ST_RESET);
endmodule
`default_nettype wire

/* File: logic/cil_pkg.sv */
/*
 * shared constants and types for the configuration init and chain block.
 * assumes a 200 MHz system clock and an AXI4-Lite register master.
 */
`default_nettype none
package cil_pkg;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_FREQ_MHZ    = 200;
   localparam int INT_OSC_MHZ     = 10;
   // internal oscillator emulated as a tick divided from clk_sys
   localparam int OSC_DIV         = CLK_FREQ_MHZ / INT_OSC_MHZ;
   localparam int INIT_CYCLES     = 3185;
   localparam int RESET_TMO_US    = 230;
   // longest time: rounds down
   localparam int RESET_TMO_CYC   = RESET_TMO_US * CLK_FREQ_MHZ;
   localparam int FLASH_PULSE_NS  = 100;
   // least time: rounds up
   localparam int FLASH_PULSE_CYC = (FLASH_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int TMO_W           = 17;
   localparam int CNT_W           = 12;
   localparam int DIV_W           = 5;
   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int          ADDR_W    = 4;
   localparam logic [3:0]  OFF_CTRL  = 4'h0;
   localparam logic [3:0]  OFF_STAT  = 4'h4;
   localparam logic [3:0]  OFF_COUNT = 4'h8;
   localparam logic [2:0]  CTRL_RST  = 3'h0;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLV  = 2'h2;
   // register selector
   typedef enum logic [1:0] {
      SEL_CTRL  = 2'h0,
      SEL_STAT  = 2'h1,
      SEL_COUNT = 2'h2,
      SEL_NONE  = 2'h3
   } cil_sel_t;
   // control register fields, bit 2 downward
   typedef struct packed {
      logic init_done_en;
      logic user_clk_sel;
      logic auto_restart;
   } cil_ctrl_t;
   // configuration stages
   typedef enum logic [2:0] {
      ST_RESET  = 3'h0,
      ST_CONFIG = 3'h1,
      ST_WAIT   = 3'h2,
      ST_INIT   = 3'h3,
      ST_USER   = 3'h4,
      ST_ERROR  = 3'h5
   } cil_state_t;
   // input synchroniser lanes
   localparam int SYNC_N   = 4;
   localparam int SY_RECFG = 0;
   localparam int SY_STAT  = 1;
   localparam int SY_DONE  = 2;
   localparam int SY_UCLK  = 3;
endpackage
`default_nettype wire

/* File: verification/cil_far_side_model.sv */
/* far side of the loader block: one passive chain peer plus the board pull-ups.
   assumes the block's open-drain enables are high while a line is pulled low. */
`timescale 1ns/1ps
`default_nettype none
module cil_far_side_model #(
   parameter int PEER_DLY = 200
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // enables from the block
   input  wire logic status_oe,
   input  wire logic done_oe,
   input  wire logic chain_oe,
   // scenario commands
   input  wire logic peer_slow,
   input  wire logic peer_fail,
   // resolved open-drain lines
   output logic      status_line_n,
   output logic      done_line
);
   // ***********
   // peer device
   // ***********
   logic [7:0] wait_reg;
   // slave loads only after the hand-off, never before
   always_ff @(posedge clk_sys) begin
      if (rst || !chain_oe) begin
         wait_reg <= 8'h00;
      end else if (wait_reg != 8'hFF) begin
         wait_reg <= wait_reg + 8'h01;
      end
   end
   // peer keeps completion low until its own data is in
   assign done_line     = !(done_oe || (wait_reg < 8'(peer_slow ? PEER_DLY : 1)));
   // a failing peer pulls status low, pull-up otherwise
   assign status_line_n = !(status_oe || peer_fail);
endmodule
`default_nettype wire

/* File: verification/config_init_and_chain_control_tb_top.sv */
/* self-checking bench for the loader block, register bus and pins.
   assumes the far side model and a 200 MHz clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module config_init_and_chain_control_tb_top;
   import cil_pkg::*;
   // ***************
   // signals
   // ***************
   localparam int TMO = 64;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic              s_axi_rvalid, s_axi_rready, bits_done, frame_err;
   logic              recfg_n, uclk, chain_in_n, peer_slow, peer_fail;
   logic              stat_n, stat_oe, done_ln, done_oe, chain_oe, idone_oe;
   logic              flash_o, flash_oe, ser_oe, pullup_en, io_en;
   int                miscompares, checks;
   cil_config_init #(.RESET_TMO(TMO)) i_dut (
      .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cfg_bits_done(bits_done), .cfg_frame_error(frame_err), .reconfig_request_n(recfg_n),
      .user_startup_clock(uclk), .error_status_line_n_i(stat_n), .error_status_line_n_o(),
      .error_status_line_n_oe(stat_oe), .load_complete_line_i(done_ln),
      .load_complete_line_o(), .load_complete_line_oe(done_oe), .chain_enable_in_n(chain_in_n),
      .chain_enable_out_n_o(), .chain_enable_out_n_oe(chain_oe), .init_done_o(),
      .init_done_oe(idone_oe), .flash_select_n_o(flash_o), .flash_select_n_oe(flash_oe),
      .serial_pins_oe(ser_oe), .user_pullup_en(pullup_en), .user_io_en(io_en));
   cil_far_side_model #(.PEER_DLY(200)) i_far (.clk_sys, .rst, .status_oe(stat_oe),
      .done_oe, .chain_oe, .peer_slow, .peer_fail, .status_line_n(stat_n), .done_line(done_ln));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ***************
   // shared tasks
   // ***************
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
      end
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rchk(input string w, input logic [3:0] a, input logic [31:0] m, exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(w, d & m, exp);
   endtask
   task automatic pulse_done;
      bits_done <= 1'b1;
      @(posedge clk_sys);
      bits_done <= 1'b0;
   endtask
   // ***************
   // scenarios
   // ***************
   task automatic t_reset_regs;
      logic [31:0] d;
      logic [1:0]  r;
      cyc(4);
      chk("status_oe", stat_oe, 1'h1);
      chk("done_oe", done_oe, 1'h1);
      chk("init_done_oe", idone_oe, 1'h0);
      rchk("stage", OFF_STAT, 32'h7, 32'h0);
      rchk("ctrl reset", OFF_CTRL, 32'h7, 32'h0);
      wr(OFF_STAT, 32'h7, r);
      chk("ro write resp", r, RESP_SLV);
      rd(4'hC, d, r);
      chk("unmapped data", d, 32'h0);
      chk("unmapped resp", r, RESP_SLV);
      wr(OFF_CTRL, 32'h5, r);
      rchk("ctrl", OFF_CTRL, 32'h7, 32'h5);
      recfg_n <= 1'b1;
      cyc(8);
      rchk("stage", OFF_STAT, 32'h7, 32'h1);
      chk("flash", {flash_oe, flash_o}, 2'h2);
      chk("chain_oe", chain_oe, 1'h0);
      chk("init_done_oe", idone_oe, 1'h0);
      $display("test reset_regs done");
   endtask
   task automatic t_frame_err;
      time t0;
      frame_err <= 1'b1;
      @(posedge clk_sys);
      frame_err <= 1'b0;
      t0 = $time;
      cyc(3);
      chk("status_oe", stat_oe, 1'h1);
      chk("done_oe", done_oe, 1'h1);
      chk("flash pulse", {flash_oe, flash_o}, 2'h3);
      rchk("stage", OFF_STAT, 32'h7, 32'h5);
      cyc(20);
      chk("flash end", {flash_oe, flash_o}, 2'h0);
      for (int i = 0; i < 200 && stat_oe !== 1'b0; i++) @(posedge clk_sys);
      chk("timeout", int'(($time - t0) / 5) inside {[TMO:TMO + 4]}, 1'h1);
      cyc(8);
      rchk("stage", OFF_STAT, 32'h7, 32'h1);
      peer_fail <= 1'b1;
      cyc(6);
      rchk("stage", OFF_STAT, 32'h7, 32'h0);
      peer_fail <= 1'b0;
      cyc(8);
      rchk("stage", OFF_STAT, 32'h7, 32'h1);
      $display("test frame_err done");
   endtask
   task automatic t_internal_init;
      time t0;
      int  el;
      peer_slow <= 1'b1;
      pulse_done();
      t0 = $time;
      cyc(3);
      chk("done_oe", done_oe, 1'h0);
      chk("chain_oe", chain_oe, 1'h1);
      chk("serial_pins_oe", ser_oe, 1'h0);
      chk("init_done_oe", idone_oe, 1'h1);
      cyc(80);
      rchk("wait stage", OFF_STAT, 32'hF, 32'h2);
      rchk("count", OFF_COUNT, 32'hFFF, 32'h0);
      for (int i = 0; i < 70000 && io_en !== 1'b1; i++) @(posedge clk_sys);
      el = int'(($time - t0) / 5);
      chk("entry", el inside {[200 + OSC_DIV * (INIT_CYCLES - 1):210 + OSC_DIV * INIT_CYCLES]},
          1'h1);
      cyc(1);
      chk("pullup_en", pullup_en, 1'h0);
      chk("init_done_oe", idone_oe, 1'h0);
      $display("test internal_init done");
   endtask
   task automatic t_reconfig;
      recfg_n <= 1'b0;
      cyc(100);
      chk("status_oe", stat_oe, 1'h1);
      chk("done_oe", done_oe, 1'h1);
      chk("user_io_en", io_en, 1'h0);
      chk("chain_oe", chain_oe, 1'h0);
      rchk("count", OFF_COUNT, 32'hFFF, 32'h0);
      recfg_n <= 1'b1;
      cyc(8);
      rchk("stage", OFF_STAT, 32'h7, 32'h1);
      $display("test reconfig done");
   endtask
   task automatic t_user_clk;
      logic [1:0] r;
      wr(OFF_CTRL, 32'h2, r);
      peer_slow <= 1'b0;
      pulse_done();
      cyc(10);
      rchk("stage", OFF_STAT, 32'h7, 32'h3);
      cyc(200);
      rchk("count", OFF_COUNT, 32'hFFF, 32'h0);
      // clock gives exactly INIT_CYCLES rising edges, then stops
      for (int i = 1; i <= INIT_CYCLES; i++) begin
         uclk <= 1'b1;
         cyc(4);
         uclk <= 1'b0;
         cyc(4);
         if (i < INIT_CYCLES && io_en === 1'b1) chk("early user", 1'h1, 1'h0);
      end
      cyc(4);
      chk("user_io_en", io_en, 1'h1);
      chk("init_done_oe", idone_oe, 1'h0);
      $display("test user_clk done");
   endtask
   // ***************
   // run
   // ***************
   initial begin
      {rst, recfg_n, uclk, chain_in_n, peer_slow, peer_fail} = 6'h20;
      {bits_done, frame_err, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      miscompares = 0;
      checks = 0;
      cyc(16);
      rst <= 1'b0;
      t_reset_regs();
      t_frame_err();
      t_internal_init();
      t_reconfig();
      t_user_clk();
      finish_test();
   end
   initial begin
      cyc(100000);
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire
